// File: src/ctf_regs.sv
// Timer and function settings registers of the charger with their timers
`timescale 1ns/10ps
module ctf_regs
    import ctf_pkg::*;
#(
    parameter int         TICK_CYCLES   = MS_TICK_CYCLES,
    parameter logic [2:0] SYS_VOLT_INIT = SYS_VOLT_CODE_RESET
)
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Register access from the serial interface engine
    input  wire ctf_req_s   regReq,
    output logic [7:0]      regRdData,
    output logic            regRdValid,
    // Analog status
    input  wire logic       inputValid,
    input  wire logic       batteryAboveDead,
    input  wire logic       batteryAboveWeak,
    input  wire logic       batteryBelowVlim,
    input  wire logic       sysBelowBattery,
    input  wire logic       trickleActive,
    input  wire logic       fastActive,
    input  wire logic       eocDetect,
    // Controls to the analog loops
    output logic            chipDisabled,
    output logic            batteryMonitorOn,
    output logic            thermistorSourceOn,
    output logic            regulatorOn,
    output logic            isoSwitchOn,
    output logic            chargeAllowed,
    output logic            endOfCharge,
    output logic            idealDiodeOn,
    output logic            tempComplianceOn,
    output logic            tempProfile,
    output logic [2:0]      systemVoltageCode,
    output logic            trickleExpired,
    output logic            fastExpired,
    output logic            watchdogExpired,
    output logic            safetyExpired
);

    // ************************************************************
    // Tick prescaler
    // ************************************************************
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

    logic [PW-1:0] pre_r;
    logic [PW-1:0] pre_nxt;
    logic          tick_r;
    logic          tick_nxt;

    always_comb begin
        tick_nxt = (pre_r == PRE_LAST);
        pre_nxt  = tick_nxt ? '0 : pre_r + PW'(1);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            pre_r  <= pre_nxt;
            tick_r <= tick_nxt;
        end
    end

    // ************************************************************
    // Register file
    // ************************************************************
    ctf_timer_s    tmr_r;
    ctf_timer_s    tmr_nxt;
    ctf_func_one_s fn1_r;
    ctf_func_one_s fn1_nxt;
    ctf_func_two_s fn2_r;
    ctf_func_two_s fn2_nxt;
    logic          wdRestart_r;
    logic          wdRestart_nxt;
    logic [7:0]    rdData_r;
    logic [7:0]    rdData_nxt;
    logic          rdValid_r;
    logic          rdValid_nxt;

    always_comb begin
        tmr_nxt       = tmr_r;
        fn1_nxt       = fn1_r;
        fn2_nxt       = fn2_r;
        wdRestart_nxt = 1'b0;
        rdValid_nxt   = regReq.read;
        rdData_nxt    = rdData_r;
        if (regReq.write) begin
            unique case (regReq.addr)
                TIMER_SETTINGS_ADDR: begin
                    tmr_nxt.doneTimerEnable =
                        regReq.wrData[TMR_DONE_EN_BIT];
                    tmr_nxt.safetyChargeTimerEnable =
                        regReq.wrData[TMR_SAFETY_EN_BIT];
                    tmr_nxt.chargeTimerLengthSel =
                        regReq.wrData[TMR_CHG_LEN_BIT];
                    tmr_nxt.hostWatchdogEnable =
                        regReq.wrData[TMR_WD_EN_BIT];
                    tmr_nxt.hostWatchdogLengthSel =
                        regReq.wrData[TMR_WD_LEN_BIT];
                    wdRestart_nxt = regReq.wrData[TMR_WD_RESTART_BIT];
                end
                FUNCTION_SETTINGS_ONE_ADDR: begin
                    fn1_nxt.chipDisable =
                        regReq.wrData[FN1_CHIP_DIS_BIT];
                    fn1_nxt.batteryMonitorForceOn =
                        regReq.wrData[FN1_BMON_BIT];
                    fn1_nxt.thermistorSourceForceOn =
                        regReq.wrData[FN1_THR_BIT];
                    fn1_nxt.regulatorOff =
                        regReq.wrData[FN1_REG_OFF_BIT];
                    fn1_nxt.endOfChargeAllow =
                        regReq.wrData[FN1_EOC_ALLOW_BIT];
                    fn1_nxt.chargingEnable =
                        regReq.wrData[FN1_CHG_EN_BIT];
                end
                FUNCTION_SETTINGS_TWO_ADDR: begin
                    // System voltage code and upper fields
                    fn2_nxt = ctf_func_two_s'(regReq.wrData);
                end
                default: begin
                    // Writes elsewhere are ignored
                end
            endcase
        end
        if (regReq.read) begin
            rdData_nxt = 8'h00;
            unique case (regReq.addr)
                TIMER_SETTINGS_ADDR: begin
                    // Unused and restart bits read zero
                    rdData_nxt = {2'h0, tmr_r, 1'b0};
                end
                FUNCTION_SETTINGS_ONE_ADDR: begin
                    rdData_nxt = {1'b0, fn1_r[5:1], 1'b0, fn1_r[0]};
                end
                FUNCTION_SETTINGS_TWO_ADDR: begin
                    rdData_nxt = fn2_r;
                end
                default: begin
                    rdData_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_r       <= ctf_timer_s'(TIMER_SETTINGS_RESET[5:1]);
            fn1_r       <= ctf_func_one_s'({FUNCTION_ONE_RESET[6:2],
                                             FUNCTION_ONE_RESET[0]});
            fn2_r       <= ctf_func_two_s'({FUNCTION_TWO_UPPER_RESET,
                                             SYS_VOLT_INIT});
            wdRestart_r <= 1'b0;
            rdData_r    <= 8'h00;
            rdValid_r   <= 1'b0;
        end else begin
            tmr_r       <= tmr_nxt;
            fn1_r       <= fn1_nxt;
            fn2_r       <= fn2_nxt;
            wdRestart_r <= wdRestart_nxt;
            rdData_r    <= rdData_nxt;
            rdValid_r   <= rdValid_nxt;
        end
    end

    // ************************************************************
    // Timer limits and run conditions
    // ************************************************************
    ctf_ticks_t trickleLimit;
    ctf_ticks_t fastLimit;
    ctf_ticks_t wdLimit;
    ctf_ticks_t safetyLimit;
    ctf_ticks_t eocLimit;
    logic       wdActive;
    logic       chargingGo;
    logic       eocRun;
    logic       eocClear;
    logic       eocElapsed;
    logic       trickleExp;
    logic       fastExp;
    logic       wdExp;
    logic       safetyExp;

    always_comb begin
        trickleLimit = tmr_r.chargeTimerLengthSel ?
                       TICKW'(TRICKLE_LONG_TICKS) :
                       TICKW'(TRICKLE_SHORT_TICKS);
        fastLimit    = tmr_r.chargeTimerLengthSel ?
                       TICKW'(FAST_LONG_TICKS) :
                       TICKW'(FAST_SHORT_TICKS);
        wdLimit      = tmr_r.hostWatchdogLengthSel ?
                       TICKW'(WD_LONG_TICKS) :
                       TICKW'(WD_SHORT_TICKS);
        safetyLimit  = TICKW'(SAFETY_TICKS);
        // Deglitch only when done timer off
        eocLimit     = tmr_r.doneTimerEnable ?
                       TICKW'(DONE_TICKS) :
                       TICKW'(DEGLITCH_TICKS);
        wdActive     = tmr_r.hostWatchdogEnable && batteryAboveDead;
        chargingGo   = fn1_r.chargingEnable && !fn1_r.chipDisable;
    end

    ctf_tick_timer u_trickle (
        .clk     (clk),
        .rst_b   (rst_b),
        .clear   (!trickleActive || !tmr_r.safetyChargeTimerEnable),
        .run     (trickleActive),
        .tick    (tick_r),
        .limit   (trickleLimit),
        .expired (trickleExp)
    );

    ctf_tick_timer u_fast (
        .clk     (clk),
        .rst_b   (rst_b),
        .clear   (!fastActive || !tmr_r.safetyChargeTimerEnable),
        .run     (fastActive),
        .tick    (tick_r),
        .limit   (fastLimit),
        .expired (fastExp)
    );

    ctf_tick_timer u_watchdog (
        .clk     (clk),
        .rst_b   (rst_b),
        .clear   (!wdActive || wdRestart_r),
        .run     (wdActive),
        .tick    (tick_r),
        .limit   (wdLimit),
        .expired (wdExp)
    );

    // Safety period starts once the watchdog has lapsed
    ctf_tick_timer u_safety (
        .clk     (clk),
        .rst_b   (rst_b),
        .clear   (!wdActive || wdRestart_r),
        .run     (wdExp),
        .tick    (tick_r),
        .limit   (safetyLimit),
        .expired (safetyExp)
    );

    // ************************************************************
    // End of charge sequencing
    // ************************************************************
    ctf_eoc_e eoc_r;
    ctf_eoc_e eoc_nxt;

    ctf_tick_timer u_eoc (
        .clk     (clk),
        .rst_b   (rst_b),
        .clear   (eocClear),
        .run     (eocRun),
        .tick    (tick_r),
        .limit   (eocLimit),
        .expired (eocElapsed)
    );

    always_comb begin
        eoc_nxt  = eoc_r;
        eocRun   = 1'b0;
        eocClear = 1'b1;
        unique case (eoc_r)
            EOC_IDLE: begin
                if (eocDetect && fn1_r.endOfChargeAllow && chargingGo) begin
                    eoc_nxt = EOC_WAIT;
                end
            end
            EOC_WAIT: begin
                eocClear = 1'b0;
                eocRun   = 1'b1;
                // Glitch on the detector restarts the wait
                if (!eocDetect || !fn1_r.endOfChargeAllow || !chargingGo) begin
                    eoc_nxt = EOC_IDLE;
                end else if (eocElapsed) begin
                    eoc_nxt = EOC_DONE;
                end
            end
            EOC_DONE: begin
                // Latched until charging is switched off
                if (!chargingGo) begin
                    eoc_nxt = EOC_IDLE;
                end
            end
        endcase
    end

    // ************************************************************
    // Output controls
    // ************************************************************
    logic [18:0] out_r;
    logic [18:0] out_nxt;
    logic        diodeOn;
    logic        vlimHold;

    always_comb begin
        unique case (fn2_r.idealDiodePolicy)
            DIODE_ALWAYS:    diodeOn = sysBelowBattery;
            DIODE_WEAK_GATE: diodeOn = sysBelowBattery && batteryAboveWeak;
            default:         diodeOn = 1'b0;
        endcase
        vlimHold = fn2_r.chargeVoltageLimitEnable && !batteryBelowVlim;
        out_nxt = {
            fn1_r.chipDisable,
            inputValid || fn1_r.batteryMonitorForceOn,
            inputValid || fn1_r.thermistorSourceForceOn,
            !fn1_r.regulatorOff && !fn1_r.chipDisable,
            fn1_r.regulatorOff ? !fn1_r.chargingEnable
                               : fn1_r.chargingEnable,
            chargingGo && !vlimHold && !trickleExp && !fastExp
                && !safetyExp && (eoc_r != EOC_DONE),
            eoc_r == EOC_DONE,
            diodeOn,
            fn2_r.tempComplianceEnable,
            fn2_r.tempProfileSel,
            fn2_r.systemVoltageCode,
            trickleExp,
            fastExp,
            wdExp,
            safetyExp,
            2'h0
        };
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            eoc_r <= EOC_IDLE;
            out_r <= '0;
        end else begin
            eoc_r <= eoc_nxt;
            out_r <= out_nxt;
        end
    end

    assign chipDisabled       = out_r[18];
    assign batteryMonitorOn   = out_r[17];
    assign thermistorSourceOn = out_r[16];
    assign regulatorOn        = out_r[15];
    assign isoSwitchOn        = out_r[14];
    assign chargeAllowed      = out_r[13];
    assign endOfCharge        = out_r[12];
    assign idealDiodeOn       = out_r[11];
    assign tempComplianceOn   = out_r[10];
    assign tempProfile        = out_r[9];
    assign systemVoltageCode  = out_r[8:6];
    assign trickleExpired     = out_r[5];
    assign fastExpired        = out_r[4];
    assign watchdogExpired    = out_r[3];
    assign safetyExpired      = out_r[2];
    assign regRdData          = rdData_r;
    assign regRdValid         = rdValid_r;

endmodule : ctf_regs

// File: src/ctf_pkg.sv
// Package of constants, field layouts and types for the timer/function bank
package ctf_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] TIMER_SETTINGS_ADDR        = 8'h06;
    localparam logic [7:0] FUNCTION_SETTINGS_ONE_ADDR = 8'h07;
    localparam logic [7:0] FUNCTION_SETTINGS_TWO_ADDR = 8'h08;

    // Timer settings field positions
    localparam int TMR_DONE_EN_BIT    = 5;
    localparam int TMR_SAFETY_EN_BIT  = 4;
    localparam int TMR_CHG_LEN_BIT    = 3;
    localparam int TMR_WD_EN_BIT      = 2;
    localparam int TMR_WD_LEN_BIT     = 1;
    localparam int TMR_WD_RESTART_BIT = 0;

    // Function settings one field positions
    localparam int FN1_CHIP_DIS_BIT   = 6;
    localparam int FN1_BMON_BIT       = 5;
    localparam int FN1_THR_BIT        = 4;
    localparam int FN1_REG_OFF_BIT    = 3;
    localparam int FN1_EOC_ALLOW_BIT  = 2;
    localparam int FN1_CHG_EN_BIT     = 0;

    // Ideal diode policy codes
    localparam logic [1:0] DIODE_ALWAYS    = 2'h0;
    localparam logic [1:0] DIODE_WEAK_GATE = 2'h1;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] TIMER_SETTINGS_RESET = 8'h38;
    localparam logic [7:0] FUNCTION_ONE_RESET   = 8'h04;
    localparam logic [4:0] FUNCTION_TWO_UPPER_RESET = 5'h00;
    localparam logic [2:0] SYS_VOLT_CODE_RESET  = 3'h2;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ         = 25_000_000;
    localparam int TICK_MS        = 1;
    localparam int MS_TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
    localparam int TICKW          = 26;

    localparam int DEGLITCH_MS      = 31;
    localparam int DONE_TIME_MS     = 100;
    localparam int TRICKLE_SHORT_S  = 30;
    localparam int TRICKLE_LONG_S   = 60;
    localparam int FAST_SHORT_MIN   = 300;
    localparam int FAST_LONG_MIN    = 600;
    localparam int WD_SHORT_S       = 32;
    localparam int WD_LONG_S        = 64;
    localparam int SAFETY_MIN       = 40;

    localparam int DEGLITCH_TICKS      = DEGLITCH_MS / TICK_MS;
    localparam int DONE_TICKS          = DONE_TIME_MS / TICK_MS;
    localparam int TRICKLE_SHORT_TICKS = TRICKLE_SHORT_S * 1000 / TICK_MS;
    localparam int TRICKLE_LONG_TICKS  = TRICKLE_LONG_S * 1000 / TICK_MS;
    localparam int FAST_SHORT_TICKS    = FAST_SHORT_MIN * 60000 / TICK_MS;
    localparam int FAST_LONG_TICKS     = FAST_LONG_MIN * 60000 / TICK_MS;
    localparam int WD_SHORT_TICKS      = WD_SHORT_S * 1000 / TICK_MS;
    localparam int WD_LONG_TICKS       = WD_LONG_S * 1000 / TICK_MS;
    localparam int SAFETY_TICKS        = SAFETY_MIN * 60000 / TICK_MS;

    // ************************************************************
    // Types
    // ************************************************************
    typedef logic [TICKW-1:0] ctf_ticks_t;

    typedef struct packed {
        logic doneTimerEnable;
        logic safetyChargeTimerEnable;
        logic chargeTimerLengthSel;
        logic hostWatchdogEnable;
        logic hostWatchdogLengthSel;
    } ctf_timer_s;

    typedef struct packed {
        logic chipDisable;
        logic batteryMonitorForceOn;
        logic thermistorSourceForceOn;
        logic regulatorOff;
        logic endOfChargeAllow;
        logic chargingEnable;
    } ctf_func_one_s;

    typedef struct packed {
        logic       tempComplianceEnable;
        logic       tempProfileSel;
        logic       chargeVoltageLimitEnable;
        logic [1:0] idealDiodePolicy;
        logic [2:0] systemVoltageCode;
    } ctf_func_two_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       write;
        logic       read;
    } ctf_req_s;

    typedef enum logic [1:0] {
        EOC_IDLE,
        EOC_WAIT,
        EOC_DONE
    } ctf_eoc_e;

endpackage : ctf_pkg

// File: src/ctf_tick_timer.sv
// Tick counter that flags expiry after a programmable number of ticks
`timescale 1ns/10ps
module ctf_tick_timer
    import ctf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clear,
    input  wire logic       run,
    input  wire logic       tick,
    input  wire ctf_ticks_t limit,
    output logic            expired
);

    ctf_ticks_t cnt_r;
    ctf_ticks_t cnt_nxt;
    logic       expired_r;
    logic       expired_nxt;

    // Expiry is sticky; only clear brings the counter back
    always_comb begin
        cnt_nxt     = cnt_r;
        expired_nxt = expired_r;
        if (clear) begin
            cnt_nxt     = '0;
            expired_nxt = 1'b0;
        end else if (run && tick && !expired_r) begin
            cnt_nxt = cnt_r + ctf_ticks_t'(1);
        end
        // An expiry that meets a clear in one cycle is kept
        if (run && tick && !expired_r
                && (cnt_r + ctf_ticks_t'(1) >= limit)) begin
            expired_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r     <= '0;
            expired_r <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            expired_r <= expired_nxt;
        end
    end

    assign expired = expired_r;

endmodule : ctf_tick_timer

// File: sim/ctf_regs_props.sv
// Concurrent checks on the timer and function settings bank
`timescale 1ns/10ps
module ctf_regs_props
    import ctf_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire ctf_req_s   regReq,
    input wire logic       regRdValid,
    input wire logic       inputValid,
    input wire logic       sysBelowBattery,
    input wire logic       chipDisabled,
    input wire logic       batteryMonitorOn,
    input wire logic       thermistorSourceOn,
    input wire logic       regulatorOn,
    input wire logic       isoSwitchOn,
    input wire logic       chargeAllowed,
    input wire logic       idealDiodeOn,
    input wire logic       tempComplianceOn,
    input wire logic       tempProfile,
    input wire logic [2:0] systemVoltageCode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wire        w7 = regReq.write && regReq.addr == 8'h07;
    wire        w8 = regReq.write && regReq.addr == 8'h08;
    logic [7:0] wd1_r;
    logic [7:0] wd2_r;
    // Write data two cycles back, lined up with the output update
    always_ff @(posedge clk) begin
        wd1_r <= regReq.wrData;
        wd2_r <= wd1_r;
    end
    chk_read_answer: assert property (
        regRdValid == $past(regReq.read))
        else $error("read not answered");
    chk_monitor_valid: assert property (
        inputValid |=> batteryMonitorOn)
        else $error("monitor off");
    chk_source_valid: assert property (
        inputValid |=> thermistorSourceOn)
        else $error("source off");
    chk_reg_switch: assert property (
        w7 |-> ##2 regulatorOn == !(wd2_r[3] || wd2_r[6])
            && isoSwitchOn == (wd2_r[3] ^ wd2_r[0]))
        else $error("regulator or switch wrong");
    chk_chip_state: assert property (
        w7 |-> ##2 chipDisabled == wd2_r[6])
        else $error("chip disable wrong");
    chk_chip_blocks: assert property (
        chargeAllowed |-> !chipDisabled)
        else $error("charging while disabled");
    chk_fn_two: assert property (
        w8 |-> ##2 {tempComplianceOn, tempProfile, systemVoltageCode}
            == {wd2_r[7:6], wd2_r[2:0]})
        else $error("second function outputs wrong");
    chk_diode_cause: assert property (
        idealDiodeOn |-> $past(sysBelowBattery))
        else $error("diode on without cause");
endmodule : ctf_regs_props

bind ctf_regs ctf_regs_props u_props (
    .clk(clk), .rst_b(rst_b), .regReq(regReq), .regRdValid(regRdValid),
    .inputValid(inputValid), .sysBelowBattery(sysBelowBattery),
    .chipDisabled(chipDisabled), .batteryMonitorOn(batteryMonitorOn),
    .thermistorSourceOn(thermistorSourceOn), .regulatorOn(regulatorOn),
    .isoSwitchOn(isoSwitchOn), .chargeAllowed(chargeAllowed),
    .idealDiodeOn(idealDiodeOn), .tempComplianceOn(tempComplianceOn),
    .tempProfile(tempProfile), .systemVoltageCode(systemVoltageCode)
);

// File: sim/charger_timer_function_regs_test.sv
// Self-checking bench for the timer and function settings bank
`timescale 1ns/10ps
module charger_timer_function_regs_test
    import ctf_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    ctf_req_s   req = '0;
    logic [7:0] ain = 8'h08;
    logic [7:0] rdData;
    logic       rdValid, chipDis, bmon, thr, regOn, iso, chgOk, eocOut;
    logic       diode, tcOn, tProf;
    logic [2:0] sysV;
    wire  [3:0] exps;
    int         miscompares = 0;
    int         nChecks = 0;
    int         cycles = 0;
    logic [7:0] isoData [4] = '{8'h01, 8'h09, 8'h08, 8'h00};
    logic [1:0] isoExp [4] = '{2'h3, 2'h0, 2'h1, 2'h2};
    localparam logic [7:0] DIODE_TAB = 8'h31;

    always #20 clk = ~clk;

    // Short tick so the end-of-charge counts fit the run
    ctf_regs #(.TICK_CYCLES(2), .SYS_VOLT_INIT(3'h5)) u_dut (
        .clk(clk), .rst_b(rst_b), .regReq(req),
        .regRdData(rdData), .regRdValid(rdValid),
        .inputValid(ain[0]), .batteryAboveDead(ain[1]),
        .batteryAboveWeak(ain[2]), .batteryBelowVlim(ain[3]),
        .sysBelowBattery(ain[4]), .trickleActive(ain[5]),
        .fastActive(ain[6]), .eocDetect(ain[7]),
        .chipDisabled(chipDis), .batteryMonitorOn(bmon),
        .thermistorSourceOn(thr), .regulatorOn(regOn),
        .isoSwitchOn(iso), .chargeAllowed(chgOk), .endOfCharge(eocOut),
        .idealDiodeOn(diode), .tempComplianceOn(tcOn),
        .tempProfile(tProf), .systemVoltageCode(sysV),
        .trickleExpired(exps[3]), .fastExpired(exps[2]),
        .watchdogExpired(exps[1]), .safetyExpired(exps[0])
    );

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Idle cycle after each strobe so the registered outputs have updated before the task returns
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{a, d, 1'b1, 1'b0};
        tick(1);
        req.write = 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        req = '{a, 8'h00, 1'b0, 1'b1};
        tick(1);
        req.read = 1'b0;
        chk({7'h0, rdValid}, 8'h01);
        chk(rdData, e);
        tick(1);
    endtask : rd

    task automatic test_done;
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic t_fields;
        rd(8'h06, 8'h38);
        rd(8'h07, 8'h04);
        rd(8'h08, 8'h05);
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h3e);
        wr(8'h06, 8'h38);
        wr(8'h07, 8'hff);
        chk({5'h0, chipDis, regOn, chgOk}, 8'h04);
        rd(8'h07, 8'h7d);
        wr(8'h07, 8'h04);
        wr(8'h08, 8'hff);
        chk({3'h0, tcOn, tProf, sysV}, 8'h1f);
        rd(8'h08, 8'hff);
        wr(8'h08, 8'h05);
        wr(8'h0a, 8'h55);
        rd(8'h0a, 8'h00);
        $display("register field test done");
    endtask : t_fields

    task automatic t_outputs;
        for (int i = 0; i < 4; i++) begin
            wr(8'h07, isoData[i]);
            chk({6'h0, regOn, iso}, {6'h0, isoExp[i]});
            if (!isoData[i][3])
                chk({7'h0, chgOk}, {7'h0, isoData[i][0]});
        end
        ain[4] = 1'b1;
        for (int i = 0; i < 8; i++) begin
            ain[2] = i[2];
            wr(8'h08, {3'h0, i[1:0], 3'h5});
            chk({7'h0, diode}, {7'h0, DIODE_TAB[i]});
        end
        ain[4] = 1'b0;
        chk({6'h0, bmon, thr}, 8'h00);
        ain[0] = 1'b1;
        tick(2);
        chk({6'h0, bmon, thr}, 8'h03);
        ain[0] = 1'b0;
        wr(8'h07, 8'h34);
        chk({6'h0, bmon, thr}, 8'h03);
        $display("output control test done");
    endtask : t_outputs

    task automatic t_eoc;
        wr(8'h07, 8'h05);
        ain[7] = 1'b1;
        tick(150);
        chk({7'h0, eocOut}, 8'h00);
        tick(100);
        chk({7'h0, eocOut}, 8'h01);
        ain[7] = 1'b0;
        wr(8'h07, 8'h00);
        wr(8'h06, 8'h18);
        wr(8'h07, 8'h05);
        ain[7] = 1'b1;
        tick(40);
        chk({7'h0, eocOut}, 8'h00);
        tick(40);
        chk({7'h0, eocOut}, 8'h01);
        ain[7] = 1'b0;
        wr(8'h07, 8'h00);
        wr(8'h07, 8'h01);
        ain[7] = 1'b1;
        tick(250);
        chk({7'h0, eocOut}, 8'h00);
        $display("end of charge test done");
    endtask : t_eoc

    // Trickle and watchdog run side by side to keep the run short
    task automatic t_timers;
        wr(8'h08, 8'h25);
        chk({7'h0, chgOk}, 8'h01);
        ain[3] = 1'b0;
        tick(1);
        chk({7'h0, chgOk}, 8'h00);
        ain[3] = 1'b1;
        wr(8'h08, 8'h05);
        wr(8'h06, 8'h14);
        ain[1] = 1'b1;
        ain[5] = 1'b1;
        tick(1000);
        wr(8'h06, 8'h15);
        tick(58990);
        chk({3'h0, chgOk, exps}, 8'h10);
        tick(20);
        chk({3'h0, chgOk, exps}, 8'h08);
        wr(8'h06, 8'h04);
        tick(1);
        chk({4'h0, exps}, 8'h00);
        tick(4980);
        chk({4'h0, exps}, 8'h00);
        tick(20);
        chk({4'h0, exps}, 8'h02);
        $display("charge timer test done");
    endtask : t_timers

    initial begin
        tick(3);
        rst_b = 1'b1;
        tick(1);
        t_fields();
        t_outputs();
        t_eoc();
        t_timers();
        test_done();
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 70000) begin
            miscompares++;
            test_done();
        end
    end
endmodule : charger_timer_function_regs_test
